// file: core/ibsf_pkg.sv
package ibsf_pkg;

  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] STATUS_OFS   = 8'h00;
  localparam logic [7:0] CONTROL_OFS  = 8'h04;
  localparam logic [7:0] LATCH_OFS    = 8'h08;
  localparam logic [7:0] INT_STAT_OFS = 8'h0C;
  localparam logic [7:0] INT_MASK_OFS = 8'h10;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int DIR_BIT    = 3;
  localparam int ACK_BIT    = 2;
  localparam int START_BIT  = 1;
  localparam int STOP_BIT   = 0;
  localparam int EN_BIT     = 7;
  localparam int EXIT_BIT   = 6;
  localparam int WREL_BIT   = 5;
  localparam int STGEN_BIT  = 1;
  localparam int MASTER_BIT = 0;
  localparam int LATCH_BIT  = 0;
  localparam int EV_STOP    = 0;
  localparam int EV_START   = 1;
  localparam int EV_ACK     = 2;
  localparam int EV_W       = 3;

  // ----------------------------------------------------------------
  // Reset values and byte clock counts
  // ----------------------------------------------------------------
  localparam logic [3:0] CNT_RST     = 4'h0;
  localparam logic [3:0] CNT_DIRBIT  = 4'h7;
  localparam logic [3:0] CNT_ACKPRE  = 4'h8;
  localparam logic [3:0] CNT_NINTH   = 4'h9;
  localparam logic [3:0] CNT_FIRST   = 4'h1;
  localparam logic       LATCH_RST   = 1'h1;
  localparam logic [2:0] MASK_RST    = 3'h0;

endpackage : ibsf_pkg

// file: core/ibsf_sync.sv
`timescale 1ns/1ps
module ibsf_sync #(
  parameter int W = 2
) (
  // Clock and reset
  input  wire logic         ref_clk_in,
  input  wire logic         rstn_in,
  // Data
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } ibsf_sync_st_t;

  ibsf_sync_st_t q;
  ibsf_sync_st_t d;

  // Pins idle high on a pulled-up bus, so reset to ones.
  always_comb begin
    d    = q;
    d.s1 = async_in;
    d.s2 = q.s1;
  end

  always_ff @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      q <= '1;
    end else begin
      q <= d;
    end
  end

  assign sync_out = q.s2;

endmodule : ibsf_sync

// file: core/ibsf_cond_det.sv
`timescale 1ns/1ps
module ibsf_cond_det (
  // Clock and reset
  input  wire logic ref_clk_in,
  input  wire logic rstn_in,
  // Synchronised lines
  input  wire logic scl_in,
  input  wire logic sda_in,
  // Events
  output logic      scl_rise_out,
  output logic      scl_fall_out,
  output logic      start_out,
  output logic      stop_out
);

  typedef struct packed {
    logic scl_p;
    logic sda_p;
  } ibsf_det_st_t;

  ibsf_det_st_t q;
  ibsf_det_st_t d;

  always_comb begin
    d       = q;
    d.scl_p = scl_in;
    d.sda_p = sda_in;
  end

  always_ff @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      q <= '1;
    end else begin
      q <= d;
    end
  end

  // ----------------------------------------------------------------
  // Edges and conditions
  // ----------------------------------------------------------------
  // Start and stop need the clock high on both samples so a clock edge never aliases.
  assign scl_rise_out = scl_in & ~q.scl_p;
  assign scl_fall_out = ~scl_in & q.scl_p;
  assign start_out    = scl_in & q.scl_p & q.sda_p & ~sda_in;
  assign stop_out     = scl_in & q.scl_p & ~q.sda_p & sda_in;

endmodule : ibsf_cond_det

// file: core/ibsf_status.sv
// The implementer's own choices: the Wishbone slave port and the address map.
`timescale 1ns/1ps
module ibsf_status (
  // Clock and reset
  input  wire logic        ref_clk_in,
  input  wire logic        rstn_in,
  // Wishbone slave
  input  wire logic        wb_cyc_in,
  input  wire logic        wb_stb_in,
  input  wire logic        wb_we_in,
  input  wire logic [7:0]  wb_adr_in,
  input  wire logic [3:0]  wb_sel_in,
  input  wire logic [31:0] wb_dat_in,
  output logic      [31:0] wb_dat_out,
  output logic             wb_ack_out,
  // Two-wire bus pins
  input  wire logic        serial_clock_line_in,
  input  wire logic        serial_data_line_in,
  output logic             serial_data_line_out,
  output logic             serial_data_line_oe_out,
  // Datapath side
  input  wire logic        arb_lost_flag_in,
  // Interrupt
  output logic             irq_out
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic                      dir;
    logic                      ack;
    logic                      start;
    logic                      stop;
    logic [3:0]                cnt;
    logic                      first;
    logic                      addr_pend;
    logic                      tx_live;
    logic                      en;
    logic                      en_prev;
    logic                      master;
    logic                      latch;
    logic                      arb_prev;
    logic [ibsf_pkg::EV_W-1:0] int_stat;
    logic [ibsf_pkg::EV_W-1:0] int_mask;
    logic                      wb_ack;
    logic [31:0]               wb_dat;
  } ibsf_st_t;

  ibsf_st_t q;
  ibsf_st_t d;

  logic [1:0] lines_s;
  logic       scl_s;
  logic       sda_s;
  logic       scl_rise;
  logic       scl_fall;
  logic       start_det;
  logic       stop_det;
  logic       bus_rise;
  logic       bus_fall;
  logic       bus_start;
  logic       bus_stop;
  logic       req;
  logic       wr;
  logic       exit_cmd;
  logic       wrel_cmd;
  logic       stgen_cmd;
  logic       en_fall;
  logic       arb_rise;
  logic       no_clear;
  logic [7:0] status;
  logic [ibsf_pkg::EV_W-1:0] ev;

  // ----------------------------------------------------------------
  // Pin synchronisers and condition detection
  // ----------------------------------------------------------------
  ibsf_sync #(
    .W (2)
  ) u_sync (
    .ref_clk_in (ref_clk_in),
    .rstn_in    (rstn_in),
    .async_in   ({serial_clock_line_in, serial_data_line_in}),
    .sync_out   (lines_s)
  );

  assign scl_s = lines_s[1];
  assign sda_s = lines_s[0];

  ibsf_cond_det u_det (
    .ref_clk_in   (ref_clk_in),
    .rstn_in      (rstn_in),
    .scl_in       (scl_s),
    .sda_in       (sda_s),
    .scl_rise_out (scl_rise),
    .scl_fall_out (scl_fall),
    .start_out    (start_det),
    .stop_out     (stop_det)
  );

  // A disabled unit ignores the bus entirely.
  assign bus_rise  = scl_rise & q.en;
  assign bus_fall  = scl_fall & q.en;
  assign bus_start = start_det & q.en;
  assign bus_stop  = stop_det & q.en;

  // ----------------------------------------------------------------
  // Bus decode and commands
  // ----------------------------------------------------------------
  assign req = wb_cyc_in & wb_stb_in & ~q.wb_ack;
  assign wr  = req & wb_we_in & wb_sel_in[0];

  // Commands act once per write and are never stored.
  assign exit_cmd  = wr & (wb_adr_in == ibsf_pkg::CONTROL_OFS)
                     & wb_dat_in[ibsf_pkg::EXIT_BIT];
  assign wrel_cmd  = wr & (wb_adr_in == ibsf_pkg::CONTROL_OFS)
                     & wb_dat_in[ibsf_pkg::WREL_BIT];
  assign stgen_cmd = wr & (wb_adr_in == ibsf_pkg::CONTROL_OFS)
                     & wb_dat_in[ibsf_pkg::STGEN_BIT];
  assign en_fall   = q.en_prev & ~q.en;
  assign arb_rise  = arb_lost_flag_in & ~q.arb_prev;
  assign no_clear  = ~exit_cmd & ~en_fall & ~wrel_cmd & ~arb_rise;

  always_comb begin
    status = 8'h00;
    status[ibsf_pkg::DIR_BIT]   = q.dir;
    status[ibsf_pkg::ACK_BIT]   = q.ack;
    status[ibsf_pkg::START_BIT] = q.start;
    status[ibsf_pkg::STOP_BIT]  = q.stop;
  end

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    d          = q;
    ev         = '0;
    d.wb_ack   = wb_cyc_in & wb_stb_in & ~q.wb_ack;
    d.en_prev  = q.en;
    d.arb_prev = arb_lost_flag_in;

    // Register reads; unmapped offsets read zero and still acknowledge.
    d.wb_dat = 32'h0000_0000;
    if (req & ~wb_we_in) begin
      unique case (wb_adr_in)
        ibsf_pkg::STATUS_OFS:   d.wb_dat[7:0] = status;
        ibsf_pkg::CONTROL_OFS: begin
          d.wb_dat[ibsf_pkg::EN_BIT]     = q.en;
          d.wb_dat[ibsf_pkg::MASTER_BIT] = q.master;
        end
        ibsf_pkg::LATCH_OFS:    d.wb_dat[ibsf_pkg::LATCH_BIT] = q.latch;
        ibsf_pkg::INT_STAT_OFS: d.wb_dat[ibsf_pkg::EV_W-1:0] = q.int_stat;
        ibsf_pkg::INT_MASK_OFS: d.wb_dat[ibsf_pkg::EV_W-1:0] = q.int_mask;
        default:                d.wb_dat = 32'h0000_0000;
      endcase
    end

    // Register writes; the status offset has no write path.
    if (wr) begin
      unique case (wb_adr_in)
        ibsf_pkg::CONTROL_OFS: begin
          d.en     = wb_dat_in[ibsf_pkg::EN_BIT];
          d.master = wb_dat_in[ibsf_pkg::MASTER_BIT];
        end
        ibsf_pkg::LATCH_OFS:    d.latch = wb_dat_in[ibsf_pkg::LATCH_BIT];
        ibsf_pkg::INT_MASK_OFS: d.int_mask = wb_dat_in[ibsf_pkg::EV_W-1:0];
        default:                d.latch = q.latch;
      endcase
    end

    // Software clears first so a bus set in the same cycle wins.
    if (exit_cmd) begin
      d.dir     = 1'b0;
      d.ack     = 1'b0;
      d.start   = 1'b0;
      d.tx_live = 1'b0;
    end
    if (wrel_cmd) begin
      d.dir     = 1'b0;
      d.tx_live = 1'b0;
    end
    if (arb_rise) begin
      d.dir = 1'b0;
    end

    // Bus conditions.
    if (bus_start) begin
      d.start     = 1'b1;
      d.cnt       = ibsf_pkg::CNT_RST;
      d.first     = 1'b1;
      d.addr_pend = 1'b1;
      d.tx_live   = 1'b0;
      ev[ibsf_pkg::EV_START] = 1'b1;
      if (!q.master) begin
        d.dir = 1'b0;
      end
    end
    if (bus_stop) begin
      d.stop      = 1'b1;
      d.dir       = 1'b0;
      d.ack       = 1'b0;
      d.first     = 1'b0;
      d.addr_pend = 1'b0;
      d.tx_live   = 1'b0;
      ev[ibsf_pkg::EV_STOP] = 1'b1;
    end
    if (stgen_cmd & q.master) begin
      d.dir = 1'b1;
    end

    // Clock rising edges count the byte.
    if (bus_rise) begin
      if (q.addr_pend) begin
        d.addr_pend = 1'b0;
        d.stop      = 1'b0;
      end
      if (q.cnt == ibsf_pkg::CNT_NINTH) begin
        d.cnt = ibsf_pkg::CNT_FIRST;
        d.ack = 1'b0;
        if (q.first) begin
          d.first = 1'b0;
          d.start = 1'b0;
        end
      end else begin
        d.cnt = 4'(q.cnt + ibsf_pkg::CNT_FIRST);
      end
      if (q.cnt == ibsf_pkg::CNT_ACKPRE && !sda_s) begin
        d.ack = 1'b1;
        ev[ibsf_pkg::EV_ACK] = 1'b1;
      end
      // The eighth clock carries the first byte's direction bit.
      if (q.cnt == ibsf_pkg::CNT_DIRBIT && q.first) begin
        d.dir = q.master ? ~sda_s : sda_s;
      end
    end

    // Output drive starts at the ninth clock fall of the first byte.
    if (bus_fall && q.cnt == ibsf_pkg::CNT_NINTH && q.first) begin
      d.tx_live = 1'b1;
    end

    // Disable overrides everything on the bus side.
    if (en_fall) begin
      d.dir       = 1'b0;
      d.ack       = 1'b0;
      d.start     = 1'b0;
      d.stop      = 1'b0;
      d.tx_live   = 1'b0;
      d.first     = 1'b0;
      d.addr_pend = 1'b0;
      d.cnt       = ibsf_pkg::CNT_RST;
    end

    // Sticky interrupt bits: write one to clear, a new event wins.
    d.int_stat = q.int_stat;
    if (wr && wb_adr_in == ibsf_pkg::INT_STAT_OFS) begin
      d.int_stat = q.int_stat & ~wb_dat_in[ibsf_pkg::EV_W-1:0];
    end
    d.int_stat = d.int_stat | ev;
  end

  always_ff @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      q          <= '0;
      q.cnt      <= ibsf_pkg::CNT_RST;
      q.latch    <= ibsf_pkg::LATCH_RST;
      q.int_mask <= ibsf_pkg::MASK_RST;
    end else begin
      q <= d;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  // Open drain: only a low latch value pulls the line.
  assign serial_data_line_out    = 1'b0;
  assign serial_data_line_oe_out = q.dir & q.tx_live & q.en
                                   & ~q.latch;
  assign wb_ack_out = q.wb_ack;
  assign wb_dat_out = q.wb_dat;
  assign irq_out    = |(q.int_stat & q.int_mask);

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge ref_clk_in);
  endclocking
  default disable iff (!rstn_in);

  a_recv_line_free: assert property (
    !q.dir |-> !serial_data_line_oe_out
  ) else $error("data line driven while receiving");

  a_drive_after_ninth: assert property (
    $rose(serial_data_line_oe_out) |-> $past(q.tx_live) || $past(bus_fall)
  ) else $error("data line driven before ninth clock fall");

  a_stop_clears_dir: assert property (
    bus_stop && !stgen_cmd |=> !q.dir && !q.ack
  ) else $error("stop did not clear direction or ack");

  a_wrel_releases: assert property (
    wrel_cmd && !bus_rise && !stgen_cmd |=> !q.dir ##0 !serial_data_line_oe_out
  ) else $error("wait release left line driven");

  a_slave_dir_set: assert property (
    bus_rise && q.cnt == 4'h7 && q.first && !q.master && sda_s && no_clear
    |=> q.dir
  ) else $error("slave did not take direction bit");

  a_ack_seen: assert property (
    bus_rise && q.cnt == 4'h8 && !sda_s && !en_fall && !exit_cmd
    |=> q.ack ##1 (q.ack || $past(bus_stop) || $past(en_fall)
                   || $past(exit_cmd))
  ) else $error("ack not flagged at ninth clock");

  a_start_flag: assert property (
    bus_start && !en_fall |=> q.start && q.addr_pend && q.cnt == 4'h0
  ) else $error("start not flagged");

  a_start_ends: assert property (
    bus_rise && q.cnt == 4'h9 && q.first && !en_fall
    |=> !q.start && q.cnt == 4'h1
  ) else $error("start flag outlived address byte");

  a_stop_flag: assert property (
    bus_stop && !en_fall |=> q.stop
  ) else $error("stop not flagged");

  a_disable_clears: assert property (
    en_fall |=> status == 8'h00
  ) else $error("disable left a flag set");

  a_status_ro: assert property (
    wr && wb_adr_in == 8'h00 && !bus_start && !bus_stop && !bus_rise
    && no_clear && !stgen_cmd |=> $stable(status)
  ) else $error("status changed by a write");

endmodule : ibsf_status

// file: verification/ibsf_bus_model.sv
`timescale 1ns/1ps
// ------------------------------------------------------------------
// Far-side bus master on open-drain lines with pull-ups.
// ------------------------------------------------------------------
module ibsf_bus_model (
  // Open-drain pull-downs, high pulls the line low
  output logic scl_low_out,
  output logic sda_low_out
);
  // Clock low phase split in two; raise it to play a slow master.
  int low_ns = 16;

  initial begin
    scl_low_out = 1'b0;
    sda_low_out = 1'b0;
  end

  // Clock is left released between frames, so it stands high.
  // Non-blocking so a pin change landing on a clock edge is seen after it.
  task automatic start_cond();
    sda_low_out <= 1'b0;
    #(low_ns);
    scl_low_out <= 1'b0;
    #32;
    sda_low_out <= 1'b1;
    #32;
    scl_low_out <= 1'b1;
    #(low_ns);
  endtask : start_cond

  task automatic stop_cond();
    sda_low_out <= 1'b1;
    #(low_ns);
    scl_low_out <= 1'b0;
    #32;
    sda_low_out <= 1'b0;
    #32;
  endtask : stop_cond

  task automatic put_bit(input logic b);
    sda_low_out <= ~b;
    #(low_ns);
    scl_low_out <= 1'b0;
    #32;
    scl_low_out <= 1'b1;
    #(low_ns);
  endtask : put_bit
endmodule : ibsf_bus_model

// file: verification/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  logic        clk, rstn, cyc, stb, we, ack, irq, arb;
  logic        scl, sda, sda_out, sda_oe, scl_low, sda_low, sel_lo;
  logic [3:0]  sel;
  logic [7:0]  adr, a;
  logic [31:0] dat_w, dat_r, rd, lfsr_q;
  int          errors, checked;

  // Open-drain wires: any party pulling low wins over the pull-up.
  assign scl = ~scl_low;
  assign sda = (sda_oe ? sda_out : 1'b1) & ~sda_low;

  ibsf_status dut (
    .ref_clk_in              (clk),
    .rstn_in                 (rstn),
    .wb_cyc_in               (cyc),
    .wb_stb_in               (stb),
    .wb_we_in                (we),
    .wb_adr_in               (adr),
    .wb_sel_in               (sel),
    .wb_dat_in               (dat_w),
    .wb_dat_out              (dat_r),
    .wb_ack_out              (ack),
    .serial_clock_line_in    (scl),
    .serial_data_line_in     (sda),
    .serial_data_line_out    (sda_out),
    .serial_data_line_oe_out (sda_oe),
    .arb_lost_flag_in        (arb),
    .irq_out                 (irq)
  );

  ibsf_bus_model u_bus (
    .scl_low_out (scl_low),
    .sda_low_out (sda_low)
  );

  // ------------------------------------------------------------------
  // Expectation and stimulus helpers
  // ------------------------------------------------------------------
  function automatic logic [31:0] st(input logic d, input logic k,
                                     input logic s, input logic p);
    logic [31:0] r;
    r = 32'h0;
    r[ibsf_pkg::DIR_BIT]   = d;
    r[ibsf_pkg::ACK_BIT]   = k;
    r[ibsf_pkg::START_BIT] = s;
    r[ibsf_pkg::STOP_BIT]  = p;
    return r;
  endfunction : st

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      errors++;
      $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic print_verdict();
    if (errors == 0 && checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : print_verdict

  // The master waits for ack however long it takes; the watchdog ends a hang.
  task automatic xfer(input logic w, input logic [7:0] ad,
                      input logic [31:0] d);
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= ad;
    dat_w <= d;
    sel <= {lfsr_q[3:1], sel_lo};
    do begin
      @(posedge clk);
    end while (ack !== 1'b1);
    rd = dat_r;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask : xfer

  task automatic wr(input logic [7:0] ad, input logic [31:0] d);
    xfer(1'b1, ad, d);
    repeat (2) @(posedge clk);
  endtask : wr

  // Lets a pin change pass the synchronisers before reading.
  task automatic rd_chk(input logic [7:0] ad, input logic [31:0] exp);
    repeat (4) @(posedge clk);
    xfer(1'b0, ad, 32'h0);
    check(rd, exp);
  endtask : rd_chk

  task automatic send(input logic [7:0] b, input int hi, input int lo);
    for (int i = hi; i >= lo; i--) begin
      u_bus.put_bit(b[i]);
    end
  endtask : send

  function automatic logic [7:0] draw(input logic lsb);
    lfsr_q = lfsr(lfsr_q);
    return {lfsr_q[7:1], lsb};
  endfunction : draw

  // ------------------------------------------------------------------
  // Clock, watchdog and main sequence
  // ------------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  initial begin
    #100000;
    errors++;
    print_verdict();
  end

  initial begin
    rstn = 1'b0;
    cyc = 1'b0;
    stb = 1'b0;
    we = 1'b0;
    adr = 8'h00;
    dat_w = 32'h0;
    arb = 1'b0;
    sel = 4'hF;
    sel_lo = 1'b1;
    errors = 0;
    checked = 0;
    lfsr_q = 32'h7269;
    repeat (6) @(posedge clk);
    rstn <= 1'b1;
    repeat (3) @(posedge clk);
    check(32'(irq), 32'h0);
    check(32'(sda_oe), 32'h0);
    rd_chk(ibsf_pkg::STATUS_OFS, 32'h0);
    rd_chk(ibsf_pkg::LATCH_OFS, 32'h1);
    // A write without the low byte lane enabled must be ignored.
    sel_lo = 1'b0;
    wr(ibsf_pkg::LATCH_OFS, 32'h0);
    sel_lo = 1'b1;
    rd_chk(ibsf_pkg::LATCH_OFS, 32'h1);
    rd_chk(ibsf_pkg::INT_MASK_OFS, 32'h0);
    rd_chk(8'h20, 32'h0);
    u_bus.start_cond();
    rd_chk(ibsf_pkg::STATUS_OFS, 32'h0);
    u_bus.stop_cond();
    wr(ibsf_pkg::CONTROL_OFS, 32'h80);
    wr(ibsf_pkg::LATCH_OFS, 32'h0);
    // Slave receives an address with the read bit set.
    u_bus.start_cond();
    rd_chk(ibsf_pkg::STATUS_OFS, st(0, 0, 1, 0));
    a = draw(1'b1);
    send(a, 7, 0);
    rd_chk(ibsf_pkg::STATUS_OFS, st(1, 0, 1, 0));
    check(32'(sda_oe), 32'h0);
    u_bus.put_bit(1'b0);
    rd_chk(ibsf_pkg::STATUS_OFS, st(1, 1, 1, 0));
    check(32'(sda_oe), 32'h1);
    wr(ibsf_pkg::STATUS_OFS, lfsr(lfsr_q));
    rd_chk(ibsf_pkg::STATUS_OFS, st(1, 1, 1, 0));
    wr(ibsf_pkg::CONTROL_OFS, 32'hA0);
    rd_chk(ibsf_pkg::STATUS_OFS, st(0, 1, 1, 0));
    check(32'(sda_oe), 32'h0);
    rd_chk(ibsf_pkg::CONTROL_OFS, 32'h80);
    u_bus.put_bit(1'b1);
    rd_chk(ibsf_pkg::STATUS_OFS, st(0, 0, 0, 0));
    u_bus.stop_cond();
    rd_chk(ibsf_pkg::STATUS_OFS, st(0, 0, 0, 1));
    rd_chk(ibsf_pkg::INT_STAT_OFS, 32'h7);
    check(32'(irq), 32'h0);
    wr(ibsf_pkg::INT_MASK_OFS, 32'h1);
    check(32'(irq), 32'h1);
    wr(ibsf_pkg::INT_STAT_OFS, 32'h7);
    check(32'(irq), 32'h0);
    rd_chk(ibsf_pkg::INT_STAT_OFS, 32'h0);
    // Slow master, write address, then software exit.
    u_bus.low_ns = 200;
    u_bus.start_cond();
    rd_chk(ibsf_pkg::STATUS_OFS, st(0, 0, 1, 1));
    a = draw(1'b0);
    send(a, 7, 7);
    rd_chk(ibsf_pkg::STATUS_OFS, st(0, 0, 1, 0));
    send(a, 6, 0);
    u_bus.put_bit(1'b0);
    rd_chk(ibsf_pkg::STATUS_OFS, st(0, 1, 1, 0));
    wr(ibsf_pkg::CONTROL_OFS, 32'hC0);
    rd_chk(ibsf_pkg::STATUS_OFS, st(0, 0, 0, 0));
    u_bus.stop_cond();
    wr(ibsf_pkg::CONTROL_OFS, 32'h00);
    rd_chk(ibsf_pkg::STATUS_OFS, st(0, 0, 0, 0));
    u_bus.low_ns = 16;
    // Master role: generated start, direction bit, arbitration loss.
    wr(ibsf_pkg::LATCH_OFS, 32'h1);
    wr(ibsf_pkg::CONTROL_OFS, 32'h81);
    u_bus.start_cond();
    wr(ibsf_pkg::CONTROL_OFS, 32'h83);
    rd_chk(ibsf_pkg::STATUS_OFS, st(1, 0, 1, 0));
    a = draw(1'b1);
    send(a, 7, 0);
    rd_chk(ibsf_pkg::STATUS_OFS, st(0, 0, 1, 0));
    u_bus.put_bit(1'b0);
    wr(ibsf_pkg::CONTROL_OFS, 32'h83);
    @(posedge clk);
    arb <= 1'b1;
    rd_chk(ibsf_pkg::STATUS_OFS, st(0, 1, 1, 0));
    wr(ibsf_pkg::CONTROL_OFS, 32'h83);
    arb <= 1'b0;
    u_bus.stop_cond();
    rd_chk(ibsf_pkg::STATUS_OFS, st(0, 0, 0, 1));
    u_bus.start_cond();
    a = draw(1'b0);
    send(a, 7, 0);
    u_bus.put_bit(1'b0);
    rd_chk(ibsf_pkg::STATUS_OFS, st(1, 1, 1, 0));
    wr(ibsf_pkg::CONTROL_OFS, 32'h01);
    rd_chk(ibsf_pkg::STATUS_OFS, st(0, 0, 0, 0));
    u_bus.stop_cond();
    print_verdict();
  end
endmodule : tb_top
